/* File: design/crtcv_defines.vh */
// crtcv_defines.vh: indices, port addresses and field positions for the
// vertical/cursor register slice of the display controller.
// assumes inclusion by bare name from design files only.
`ifndef CRTCV_DEFINES_VH
`define CRTCV_DEFINES_VH

// i/o port addresses, selected by miscellaneous output bit 0
`define CRTCV_MONO_ADDR_PORT 16'h03B4
`define CRTCV_MONO_DATA_PORT 16'h03B5
`define CRTCV_COLR_ADDR_PORT 16'h03D4
`define CRTCV_COLR_DATA_PORT 16'h03D5

// register indices
`define CRTCV_IDX_VTOTAL 5'h06
`define CRTCV_IDX_OVFL 5'h07
`define CRTCV_IDX_PRESET 5'h08
`define CRTCV_IDX_MAXSCAN 5'h09
`define CRTCV_IDX_CUR_START 5'h0A
`define CRTCV_IDX_CUR_END 5'h0B
`define CRTCV_IDX_SADDR_HI 5'h0C
`define CRTCV_IDX_SADDR_LO 5'h0D
`define CRTCV_IDX_CLOC_HI 5'h0E
`define CRTCV_IDX_CLOC_LO 5'h0F
`define CRTCV_IDX_VRS 5'h10

// reset value of every register in the slice
`define CRTCV_REG_RESET 8'h00

// overflow field positions
`define CRTCV_OV_VT8 0
`define CRTCV_OV_VDE8 1
`define CRTCV_OV_VRS8 2
`define CRTCV_OV_SVB8 3
`define CRTCV_OV_LC8 4
`define CRTCV_OV_VT9 5
`define CRTCV_OV_VDE9 6
`define CRTCV_OV_VRS9 7
// overflow bits locked by lock bit 0 or write protect
`define CRTCV_OV_MASK_A 8'hAD
// overflow bits locked by lock bit 1 low and write protect
`define CRTCV_OV_MASK_B 8'h42

// maximum scan line field positions
`define CRTCV_MS_SVB9 5
`define CRTCV_MS_LC9 6
`define CRTCV_MS_DOUBLE 7

// cursor start control bit
`define CRTCV_CS_OFF 5

// lock register bit positions
`define CRTCV_LK_TIMING 0
`define CRTCV_LK_VDE 1
`define CRTCV_LK_ADDR_LO 3
`define CRTCV_LK_ADDR_HI 4

`endif

/* File: design/crtcv_rowscan.v */
// crtcv_rowscan.v: row scan counter with preset load and line doubling.
// assumes one-cycle retrace-end pulses from logic on the same clock.
`timescale 1ns/1ps

module crtcv_rowscan #(
   parameter W = 5
) (
   input wire clk, // system clock
   input wire rst_n, // synchronised reset, active low
   input wire ce, // character clock enable
   input wire hret_end, // pulse at end of horizontal retrace
   input wire vret_end, // pulse at end of vertical retrace
   input wire [W-1:0] preset, // preset row value
   input wire [W-1:0] max_row, // last row scan value
   input wire double_en, // line doubling enable
   output reg [W-1:0] row_r // row scan count
);

   reg half_r;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         row_r <= {W{1'b0}};
         half_r <= 1'b0;
      end else if (ce) begin
         if (vret_end) begin
            row_r <= preset; // see RULE7
            half_r <= 1'b0;
         end else if (hret_end) begin
            half_r <= ~half_r;
            // every other line when doubling
            if (!double_en || half_r) begin // see RULE8
               if (row_r >= max_row)
                  row_r <= {W{1'b0}}; // see RULE7
               else
                  row_r <= row_r + {{(W-1){1'b0}}, 1'b1}; // see RULE7
            end
         end
      end
   end

endmodule // crtcv_rowscan

/* File: design/crtcv_regs.v */
// crtcv_regs.v: vertical timing, scan and cursor register slice of the
// display controller, reached through the index/data i/o port pair.
// assumes lock register, write-protect, mode and counter inputs come from
// logic on the same clock; ce is the character clock enable.
//
// Summary of operation
// RULE1 - vertical total is a 10-bit line count minus 2; bits 8,9 from overflow
// RULE2 - legacy mode: vertical total is rows in bits 6..0, bit 7 reserved
// RULE3 - vertical total writes ignored when lock bit 0 or write protect set
// RULE4 - overflow register carries high bits of several vertical values
// RULE5 - overflow bits 6,1 and 7,5,3,2,0 have separate lock conditions
// RULE6 - byte panning field pans display left 0 to 3 bytes
// RULE7 - row counter preset after vertical retrace, steps per line, wraps at max
// RULE8 - line doubling clocks row counter at half the line rate
// RULE9 - rows per character are max scan field plus one; legacy bits reserved
// RULE10 - max scan bit 6 is line compare bit 9, bit 5 blank bit 9, lockable
// RULE11 - cursor starts at start row, bit 5 disables, none if start above end
// RULE12 - cursor active through end row, none if end below start
// RULE13 - cursor skew delays cursor right by 0 to 3 character clocks
// RULE14 - start address is 16 bits extended to 18 by lock bits 3,4
// RULE15 - legacy mode forces start address high bits 7,6 to zero
// RULE16 - cursor location 16 bits extended to 18; legacy uses high bits 5..0
// RULE17 - retrace start 10 bits with overflow bits; writes locked by lock bit 0
// RULE18 - retrace start reads light pen bits in legacy and ega modes
// RULE19 - index written to address port bits 4..0, register reached via data port
// RULE20 - port pair at 3b4/3b5 or 3d4/3d5 chosen by misc output bit 0
// RULE21 - all slice registers clear to zero on reset
`timescale 1ns/1ps
`include "crtcv_defines.vh"

module crtcv_regs #(
   parameter AW = 18,
   parameter RW = 5
) (
   input wire clk, // 50 mhz system clock
   input wire reset_n, // asynchronous reset, active low
   input wire ce, // character clock enable, freezes all state but the reset synchroniser when low
   input wire [15:0] io_addr, // host i/o address
   input wire io_wr, // host i/o write strobe
   input wire io_rd, // host i/o read strobe
   input wire [7:0] io_wdata, // host write data
   output reg [7:0] io_rdata_r, // read data, valid the cycle after io_rd
   input wire misc_color, // miscellaneous output bit 0
   input wire [7:0] lock_extension_reg, // external lock register
   input wire write_protect, // retrace end register bit 7
   input wire legacy_mode, // legacy character controller mode
   input wire ega_mode, // ega compatible mode
   input wire multi_shift, // multiple shift mode active
   input wire [15:0] light_pen, // light pen latch
   input wire hretrace, // horizontal retrace level
   input wire vretrace, // vertical retrace level
   input wire [AW-1:0] mem_addr, // memory address counter
   output reg [9:0] vtotal_r, // vertical total
   output reg [9:0] vde_end_hi_r, // display enable end high bits at 9:8
   output reg [9:0] vret_start_r, // vertical retrace start
   output reg [1:0] svb_hi_r, // start vertical blank bits 9:8
   output reg [1:0] line_cmp_hi_r, // line compare bits 9:8
   output reg [1:0] byte_pan_r, // effective byte pan
   output reg [5:0] rows_per_char_r, // scan lines per character row
   output reg [RW-1:0] row_scan_r, // row scan counter
   output reg [AW-1:0] start_addr_r, // refresh start address
   output reg [AW-1:0] cursor_addr_r, // cursor location
   output reg cursor_r // skewed cursor active
);

   reg rst_m_r;
   reg rst_s_r;
   reg [4:0] index_r;
   reg [7:0] vt_r;
   reg [7:0] ov_r;
   reg [7:0] prs_r;
   reg [7:0] ms_r;
   reg [7:0] cs_r;
   reg [7:0] cend_r;
   reg [7:0] sah_r;
   reg [7:0] sal_r;
   reg [7:0] clh_r;
   reg [7:0] cll_r;
   reg [7:0] vrs_r;
   reg hret_d_r;
   reg vret_d_r;
   reg [3:0] cur_pipe_r;
   reg [7:0] rd_nxt;
   reg [7:0] ov_keep;
   wire addr_hit;
   wire data_hit;
   wire wr_data;
   wire lock_t;
   wire lock_v;
   wire hret_end;
   wire vret_end;
   wire [RW-1:0] row_now;
   wire [4:0] max_eff;
   wire dbl_eff;
   wire cur_row_ok;
   wire cur_raw;
   wire [7:0] sah_eff;
   wire [7:0] clh_eff;

   // reset release through two flops
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_m_r <= 1'b0;
         rst_s_r <= 1'b0;
      end else begin
         rst_m_r <= 1'b1;
         rst_s_r <= rst_m_r;
      end
   end

   assign addr_hit = io_addr == (misc_color ? `CRTCV_COLR_ADDR_PORT : `CRTCV_MONO_ADDR_PORT); // see RULE20
   assign data_hit = io_addr == (misc_color ? `CRTCV_COLR_DATA_PORT : `CRTCV_MONO_DATA_PORT); // see RULE20
   assign wr_data = io_wr && data_hit;
   assign lock_t = lock_extension_reg[`CRTCV_LK_TIMING];
   // display-enable-end lock: lock bit 1 low and protect set
   assign lock_v = !lock_extension_reg[`CRTCV_LK_VDE] && write_protect;

   // overflow bits kept on write; bit 4 never protected
   always @* begin
      ov_keep = 8'h00;
      if (lock_t || write_protect)
         ov_keep = ov_keep | `CRTCV_OV_MASK_A; // see RULE5
      if (lock_v)
         ov_keep = ov_keep | `CRTCV_OV_MASK_B; // see RULE5
   end

   // register file
   always @(posedge clk or negedge rst_s_r) begin
      if (!rst_s_r) begin
         index_r <= 5'h00;
         vt_r <= `CRTCV_REG_RESET; // see RULE21
         ov_r <= `CRTCV_REG_RESET;
         prs_r <= `CRTCV_REG_RESET;
         ms_r <= `CRTCV_REG_RESET;
         cs_r <= `CRTCV_REG_RESET;
         cend_r <= `CRTCV_REG_RESET;
         sah_r <= `CRTCV_REG_RESET;
         sal_r <= `CRTCV_REG_RESET;
         clh_r <= `CRTCV_REG_RESET;
         cll_r <= `CRTCV_REG_RESET;
         vrs_r <= `CRTCV_REG_RESET;
      end else if (ce) begin
         if (io_wr && addr_hit)
            index_r <= io_wdata[4:0]; // see RULE19
         if (wr_data) begin
            case (index_r) // see RULE19
               `CRTCV_IDX_VTOTAL: begin
                  if (!(lock_t || write_protect))
                     vt_r <= io_wdata; // see RULE3
               end
               `CRTCV_IDX_OVFL: ov_r <= (ov_r & ov_keep) | (io_wdata & ~ov_keep); // see RULE5
               `CRTCV_IDX_PRESET: prs_r <= io_wdata;
               `CRTCV_IDX_MAXSCAN: begin
                  // blank bit 9 holds its value while timing is locked
                  ms_r <= lock_t ? {io_wdata[7:6], ms_r[5], io_wdata[4:0]} : io_wdata; // see RULE10
               end
               `CRTCV_IDX_CUR_START: cs_r <= io_wdata;
               `CRTCV_IDX_CUR_END: cend_r <= io_wdata;
               `CRTCV_IDX_SADDR_HI: sah_r <= io_wdata;
               `CRTCV_IDX_SADDR_LO: sal_r <= io_wdata;
               `CRTCV_IDX_CLOC_HI: clh_r <= io_wdata;
               `CRTCV_IDX_CLOC_LO: cll_r <= io_wdata;
               `CRTCV_IDX_VRS: begin
                  if (!lock_t)
                     vrs_r <= io_wdata; // see RULE17
               end
               default: begin
               end
            endcase
         end
      end
   end

   // read mux; unmapped indices and reserved address bits read zero
   always @* begin
      rd_nxt = 8'h00;
      if (addr_hit)
         rd_nxt = {3'b000, index_r};
      else if (data_hit) begin
         case (index_r)
            `CRTCV_IDX_VTOTAL: rd_nxt = vt_r;
            `CRTCV_IDX_OVFL: rd_nxt = ov_r;
            `CRTCV_IDX_PRESET: rd_nxt = prs_r;
            `CRTCV_IDX_MAXSCAN: rd_nxt = ms_r;
            `CRTCV_IDX_CUR_START: rd_nxt = cs_r;
            `CRTCV_IDX_CUR_END: rd_nxt = cend_r;
            `CRTCV_IDX_SADDR_HI: rd_nxt = sah_r;
            `CRTCV_IDX_SADDR_LO: rd_nxt = sal_r;
            `CRTCV_IDX_CLOC_HI: rd_nxt = clh_r;
            `CRTCV_IDX_CLOC_LO: rd_nxt = cll_r;
            `CRTCV_IDX_VRS: begin
               if (legacy_mode)
                  rd_nxt = {2'b00, light_pen[15:10]}; // see RULE18
               else if (ega_mode)
                  rd_nxt = light_pen[15:8]; // see RULE18
               else
                  rd_nxt = vrs_r;
            end
            default: rd_nxt = 8'h00;
         endcase
      end
   end

   always @(posedge clk or negedge rst_s_r) begin
      if (!rst_s_r)
         io_rdata_r <= 8'h00;
      else if (ce && io_rd)
         io_rdata_r <= rd_nxt;
   end

   // retrace end pulses from the same-clock timing logic
   always @(posedge clk or negedge rst_s_r) begin
      if (!rst_s_r) begin
         hret_d_r <= 1'b0;
         vret_d_r <= 1'b0;
      end else if (ce) begin
         hret_d_r <= hretrace;
         vret_d_r <= vretrace;
      end
   end
   assign hret_end = hret_d_r && !hretrace;
   assign vret_end = vret_d_r && !vretrace;

   // legacy mode treats bit 7 of max scan as reserved; bits 6,5 still feed the high bits
   assign max_eff = ms_r[4:0]; // see RULE9
   assign dbl_eff = ms_r[`CRTCV_MS_DOUBLE] && !legacy_mode; // see RULE9

   crtcv_rowscan #(
      .W(RW)
   ) crtcv_rowscan_inst (
      .clk(clk),
      .rst_n(rst_s_r),
      .ce(ce),
      .hret_end(hret_end),
      .vret_end(vret_end),
      .preset(prs_r[RW-1:0]),
      .max_row(max_eff[RW-1:0]),
      .double_en(dbl_eff),
      .row_r(row_now)
   );

   assign sah_eff = legacy_mode ? {2'b00, sah_r[5:0]} : sah_r; // see RULE15
   assign clh_eff = legacy_mode ? {2'b00, clh_r[5:0]} : clh_r; // see RULE16

   // no cursor when start lies above end; bit 5 turns it off
   assign cur_row_ok = !cs_r[`CRTCV_CS_OFF] && (cs_r[4:0] <= cend_r[4:0]) && // see RULE11
      (row_now >= cs_r[4:0]) && (row_now <= cend_r[4:0]); // see RULE12
   assign cur_raw = cur_row_ok && (mem_addr == cursor_addr_r);

   // derived outputs, all registered
   always @(posedge clk or negedge rst_s_r) begin
      if (!rst_s_r) begin
         vtotal_r <= 10'h000;
         vde_end_hi_r <= 10'h000;
         vret_start_r <= 10'h000;
         svb_hi_r <= 2'b00;
         line_cmp_hi_r <= 2'b00;
         byte_pan_r <= 2'b00;
         rows_per_char_r <= 6'h00;
         row_scan_r <= {RW{1'b0}};
         start_addr_r <= {AW{1'b0}};
         cursor_addr_r <= {AW{1'b0}};
         cur_pipe_r <= 4'h0;
         cursor_r <= 1'b0;
      end else if (ce) begin
         if (legacy_mode)
            vtotal_r <= {3'b000, vt_r[6:0]}; // see RULE2
         else
            vtotal_r <= {ov_r[`CRTCV_OV_VT9], ov_r[`CRTCV_OV_VT8], vt_r}; // see RULE1
         vde_end_hi_r <= {ov_r[`CRTCV_OV_VDE9], ov_r[`CRTCV_OV_VDE8], 8'h00}; // see RULE4
         vret_start_r <= {ov_r[`CRTCV_OV_VRS9], ov_r[`CRTCV_OV_VRS8], vrs_r}; // see RULE17
         svb_hi_r <= {ms_r[`CRTCV_MS_SVB9], ov_r[`CRTCV_OV_SVB8]}; // see RULE10
         line_cmp_hi_r <= {ms_r[`CRTCV_MS_LC9], ov_r[`CRTCV_OV_LC8]}; // see RULE10
         byte_pan_r <= multi_shift ? prs_r[6:5] : 2'b00; // see RULE6
         rows_per_char_r <= {1'b0, max_eff} + 6'h01; // see RULE9
         row_scan_r <= row_now;
         start_addr_r <= {lock_extension_reg[`CRTCV_LK_ADDR_HI], lock_extension_reg[`CRTCV_LK_ADDR_LO],
            sah_eff, sal_r}; // see RULE14
         cursor_addr_r <= {lock_extension_reg[`CRTCV_LK_ADDR_HI], lock_extension_reg[`CRTCV_LK_ADDR_LO],
            clh_eff, cll_r}; // see RULE16
         cur_pipe_r <= {cur_pipe_r[2:0], cur_raw};
         cursor_r <= cur_pipe_r[cend_r[6:5]]; // see RULE13
      end
   end

endmodule // crtcv_regs

/* File: sim/crtcv_regs_asserts.sv */
// crtcv_regs_asserts.sv: port-level timing checks on the register slice.
// assumes ce high, lock quiet around reset, bound to crtcv_regs.
`timescale 1ns/1ps

module crtcv_regs_asserts #(
   parameter AW = 18
) (
   input wire clk, // clock
   input wire reset_n, // reset, active low
   input wire ce, // char enable
   input wire [15:0] io_addr, // i/o address
   input wire io_wr, // write strobe
   input wire io_rd, // read strobe
   input wire [7:0] io_wdata, // write data
   input wire [7:0] io_rdata_r, // read data
   input wire misc_color, // port select
   input wire [7:0] lock_extension_reg, // lock register
   input wire write_protect, // write protect
   input wire legacy_mode, // legacy mode
   input wire multi_shift, // shift mode
   input wire [AW-1:0] mem_addr, // scan address
   input wire [9:0] vtotal_r, // vertical total
   input wire [9:0] vret_start_r, // retrace start
   input wire [1:0] byte_pan_r, // byte pan
   input wire [AW-1:0] start_addr_r, // start address
   input wire [AW-1:0] cursor_addr_r, // cursor address
   input wire cursor_r // cursor
);
   reg [2:0] ok_r;
   reg [4:0] idx_r;
   wire [15:0] base = misc_color ? 16'h03D4 : 16'h03B4;
   wire dwr = ce && io_wr && io_addr == base + 16'h0001;
   // extends the two-flop release by one stage, so the design's reset tail is skipped
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ok_r <= 3'h0;
         idx_r <= 5'h00;
      end else begin
         ok_r <= {ok_r[1:0], 1'b1};
         if (ce && io_wr && io_addr == base)
            idx_r <= io_wdata[4:0];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!ok_r[2]);
   sequence s_wr(i);
      dwr && idx_r == i;
   endsequence
   AST_RESET_CLEAR: assert property (disable iff (!reset_n)
      $rose(ok_r[2]) |-> vtotal_r == 10'h000 && vret_start_r == 10'h000 && ~|start_addr_r && ~|cursor_addr_r)
      else $error("outputs not clear after reset");
   AST_VT_WRITE: assert property (
      s_wr(5'h06) ##0 (!lock_extension_reg[0] && !write_protect && !legacy_mode) |->
      ##2 vtotal_r[7:0] == $past(io_wdata, 2)) else $error("vertical total write lost");
   AST_VT_LOCK: assert property (
      s_wr(5'h06) ##0 (lock_extension_reg[0] || write_protect) |=> $stable(vtotal_r) [*2])
      else $error("locked vertical total changed");
   AST_VRS_LOCK: assert property (
      s_wr(5'h10) ##0 lock_extension_reg[0] |=> $stable(vret_start_r) [*2])
      else $error("locked retrace start changed");
   AST_ADDR_EXT: assert property (
      $stable(lock_extension_reg) [*3] |-> start_addr_r[17:16] == lock_extension_reg[4:3] &&
      cursor_addr_r[17:16] == lock_extension_reg[4:3]) else $error("address extension bits wrong");
   AST_CUR_NOMATCH: assert property (
      (mem_addr != cursor_addr_r) [*6] |-> !cursor_r) else $error("cursor away from its location");
   AST_PAN_OFF: assert property (
      !multi_shift [*3] |-> byte_pan_r == 2'h0) else $error("pan outside shift mode");
   AST_RDATA_HOLD: assert property (
      !(ce && io_rd) |=> $stable(io_rdata_r)) else $error("read data moved without a read");
endmodule // crtcv_regs_asserts

bind crtcv_regs crtcv_regs_asserts #(.AW(AW)) crtcv_regs_asserts_inst (.clk(clk), .reset_n(reset_n),
   .ce(ce), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_r(io_rdata_r),
   .misc_color(misc_color), .lock_extension_reg(lock_extension_reg), .write_protect(write_protect),
   .legacy_mode(legacy_mode), .multi_shift(multi_shift), .mem_addr(mem_addr), .vtotal_r(vtotal_r),
   .vret_start_r(vret_start_r), .byte_pan_r(byte_pan_r), .start_addr_r(start_addr_r),
   .cursor_addr_r(cursor_addr_r), .cursor_r(cursor_r));

/* File: sim/crtcv_host_model.sv */
// crtcv_host_model.sv: host processor i/o cycles on the index/data port pair.
// assumes one calling process; ce held high by the bench.
`timescale 1ns/1ps

module crtcv_host_model (
   input wire clk, // clock
   input wire misc_color, // port base select
   input wire [7:0] io_rdata_r, // read data
   output reg [15:0] io_addr, // i/o address
   output reg io_wr, // write strobe
   output reg io_rd, // read strobe
   output reg [7:0] io_wdata // write data
);
   initial begin
      io_addr = 16'h0000;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end
   // data goes stale after release so a late sample cannot match by luck
   task pw(input [15:0] p, input [7:0] d);
      begin
         @(posedge clk);
         io_addr <= p;
         io_wdata <= d;
         io_wr <= 1'b1;
         @(posedge clk);
         io_wr <= 1'b0;
         io_wdata <= ~d;
      end
   endtask
   task rw(input [4:0] i, input [7:0] d);
      begin
         pw(misc_color ? 16'h03D4 : 16'h03B4, {3'h0, i});
         pw(misc_color ? 16'h03D5 : 16'h03B5, d);
      end
   endtask
   task rr(input [4:0] i, output [7:0] d);
      begin
         pw(misc_color ? 16'h03D4 : 16'h03B4, {3'h0, i});
         @(posedge clk);
         io_addr <= misc_color ? 16'h03D5 : 16'h03B5;
         io_rd <= 1'b1;
         @(posedge clk);
         io_rd <= 1'b0;
         @(posedge clk);
         d = io_rdata_r;
      end
   endtask
endmodule // crtcv_host_model

/* File: sim/test_crtc_vertical_cursor_regs.sv */
// test_crtc_vertical_cursor_regs.sv: self-checking bench for the register slice.
// assumes the host model owns the port pair; ce and light pen stay fixed.
`timescale 1ns/1ps

module test_crtc_vertical_cursor_regs;
   reg clk, reset_n, misc_color, write_protect, legacy_mode, ega_mode, multi_shift, hretrace, vretrace;
   reg [7:0] lock_extension_reg;
   reg [7:0] rd;
   reg [17:0] mem_addr;
   integer n_fail, checked, cyc, i, n;
   wire [15:0] io_addr;
   wire io_wr, io_rd, cursor_r;
   wire [7:0] io_wdata, io_rdata_r;
   wire [9:0] vtotal_r, vde_end_hi_r, vret_start_r;
   wire [1:0] svb_hi_r, line_cmp_hi_r, byte_pan_r;
   wire [5:0] rows_per_char_r;
   wire [4:0] row_scan_r;
   wire [17:0] start_addr_r, cursor_addr_r;
   crtcv_regs crtcv_regs_inst (.clk(clk), .reset_n(reset_n), .ce(1'b1), .io_addr(io_addr), .io_wr(io_wr),
      .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_r(io_rdata_r), .misc_color(misc_color),
      .lock_extension_reg(lock_extension_reg), .write_protect(write_protect), .legacy_mode(legacy_mode),
      .ega_mode(ega_mode), .multi_shift(multi_shift), .light_pen(16'hBEEF), .hretrace(hretrace),
      .vretrace(vretrace), .mem_addr(mem_addr), .vtotal_r(vtotal_r), .vde_end_hi_r(vde_end_hi_r),
      .vret_start_r(vret_start_r), .svb_hi_r(svb_hi_r), .line_cmp_hi_r(line_cmp_hi_r), .byte_pan_r(byte_pan_r),
      .rows_per_char_r(rows_per_char_r), .row_scan_r(row_scan_r), .start_addr_r(start_addr_r),
      .cursor_addr_r(cursor_addr_r), .cursor_r(cursor_r));
   crtcv_host_model crtcv_host_model_inst (.clk(clk), .misc_color(misc_color), .io_rdata_r(io_rdata_r),
      .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
   task chk(input [63:0] nm, input [17:0] e, input [17:0] g);
      begin
         checked = checked + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task rdc(input [4:0] x, input [7:0] e);
      begin
         crtcv_host_model_inst.rr(x, rd);
         chk("rdata", {10'h000, e}, {10'h000, rd});
      end
   endtask
   // retrace held two cycles, then time for the lagging row copy
   task pulse(input v);
      begin
         @(posedge clk);
         if (v) vretrace <= 1'b1; else hretrace <= 1'b1;
         repeat (2) @(posedge clk);
         vretrace <= 1'b0;
         hretrace <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   task t_reset;
      for (i = 6; i < 18; i = i + 1) rdc(i[4:0], 8'h00);
   endtask
   task t_rw;
      begin
         for (i = 6; i < 17; i = i + 1) crtcv_host_model_inst.rw(i[4:0], {i[3:0], ~i[3:0]});
         for (i = 6; i < 17; i = i + 1) rdc(i[4:0], {i[3:0], ~i[3:0]});
         chk("vtotal", 18'h0_0269, {8'h00, vtotal_r});
         chk("vretrace", 18'h0_000F, {8'h00, vret_start_r});
         chk("start", 18'h0_C3D2, start_addr_r);
         chk("cursor", 18'h0_E1F0, cursor_addr_r);
         chk("rows", 18'h0_0017, {12'h000, rows_per_char_r});
         chk("hibits", 18'h0_0005, {14'h0000, svb_hi_r, line_cmp_hi_r});
      end
   endtask
   task t_lock;
      begin
         @(posedge clk);
         write_protect <= 1'b1;
         crtcv_host_model_inst.rw(5'h06, 8'h00);
         crtcv_host_model_inst.rw(5'h07, 8'h00);
         rdc(5'h06, 8'h69);
         rdc(5'h07, 8'h68);
         lock_extension_reg <= 8'h02;
         crtcv_host_model_inst.rw(5'h07, 8'hFF);
         rdc(5'h07, 8'h7A);
         chk("vdehi", 18'h0_0300, {8'h00, vde_end_hi_r});
         write_protect <= 1'b0;
         lock_extension_reg <= 8'h19;
         crtcv_host_model_inst.rw(5'h10, 8'hFF);
         crtcv_host_model_inst.rw(5'h09, 8'h20);
         rdc(5'h10, 8'h0F);
         rdc(5'h09, 8'h00);
         chk("start", 18'h3_C3D2, start_addr_r);
         lock_extension_reg <= 8'h00;
      end
   endtask
   task t_modes;
      begin
         @(posedge clk);
         legacy_mode <= 1'b1;
         rdc(5'h10, 8'h2F);
         chk("start", 18'h0_03D2, start_addr_r);
         chk("cursor", 18'h0_21F0, cursor_addr_r);
         chk("vtotal", 18'h0_0069, {8'h00, vtotal_r});
         legacy_mode <= 1'b0;
         ega_mode <= 1'b1;
         rdc(5'h10, 8'hBE);
         ega_mode <= 1'b0;
      end
   endtask
   task t_ports;
      begin
         @(posedge clk);
         misc_color <= 1'b0;
         @(posedge clk);
         crtcv_host_model_inst.rw(5'h0D, 8'h5A);
         crtcv_host_model_inst.pw(16'h03D4, 8'h0D);
         crtcv_host_model_inst.pw(16'h03D5, 8'hFF);
         rdc(5'h0D, 8'h5A);
         crtcv_host_model_inst.rw(5'h11, 8'hFF);
         rdc(5'h11, 8'h00);
         misc_color <= 1'b1;
         @(posedge clk);
      end
   endtask
   // edges from the scan address reaching the cursor to cursor_r high: 3 plus skew
   task cur_lat(input [7:0] endv, input [17:0] e);
      begin
         crtcv_host_model_inst.rw(5'h0B, endv);
         @(posedge clk);
         mem_addr <= 18'h0_0001;
         repeat (8) @(posedge clk);
         mem_addr <= 18'h0_0000;
         n = 0;
         while (cursor_r !== 1'b1 && n < 10) begin
            @(negedge clk);
            n = n + 1;
         end
         chk("curdelay", e, n[17:0]);
      end
   endtask
   task t_cursor;
      begin
         crtcv_host_model_inst.rw(5'h0E, 8'h00);
         crtcv_host_model_inst.rw(5'h0F, 8'h00);
         crtcv_host_model_inst.rw(5'h0A, 8'h00);
         cur_lat(8'h00, 18'h0_0003);
         cur_lat(8'h60, 18'h0_0006);
         crtcv_host_model_inst.rw(5'h0A, 8'h20);
         repeat (8) @(posedge clk);
         chk("curon", 18'h0_0000, {17'h0_0000, cursor_r});
         crtcv_host_model_inst.rw(5'h0A, 8'h00);
         repeat (8) @(posedge clk);
         chk("curon", 18'h0_0001, {17'h0_0000, cursor_r});
         crtcv_host_model_inst.rw(5'h0A, 8'h01);
         repeat (8) @(posedge clk);
         chk("curon", 18'h0_0000, {17'h0_0000, cursor_r});
      end
   endtask
   task t_rows;
      begin
         crtcv_host_model_inst.rw(5'h08, 8'h43);
         crtcv_host_model_inst.rw(5'h09, 8'h04);
         multi_shift <= 1'b1;
         pulse(1'b1);
         chk("row", 18'h0_0003, {13'h0000, row_scan_r});
         chk("pan", 18'h0_0002, {16'h0000, byte_pan_r});
         pulse(1'b0);
         chk("row", 18'h0_0004, {13'h0000, row_scan_r});
         pulse(1'b0);
         chk("row", 18'h0_0000, {13'h0000, row_scan_r});
         pulse(1'b0);
         chk("row", 18'h0_0001, {13'h0000, row_scan_r});
         crtcv_host_model_inst.rw(5'h09, 8'h84);
         pulse(1'b1);
         pulse(1'b0);
         pulse(1'b0);
         chk("row", 18'h0_0004, {13'h0000, row_scan_r});
         pulse(1'b0);
         pulse(1'b0);
         chk("row", 18'h0_0000, {13'h0000, row_scan_r});
      end
   endtask
   task results;
      begin
         if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      reset_n = 1'b0;
      {misc_color, write_protect, legacy_mode, ega_mode, multi_shift, hretrace, vretrace} = 7'h40;
      lock_extension_reg = 8'h00;
      mem_addr = 18'h0_0000;
      n_fail = 0;
      checked = 0;
      cyc = 0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset;
      t_rw;
      t_lock;
      t_modes;
      t_ports;
      t_cursor;
      t_rows;
      results;
   end
   // the whole run needs a few hundred cycles
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         results;
      end
   end
endmodule // test_crtc_vertical_cursor_regs
